//--- design/qps_device.sv
// Device end: serial slave front end of the quad pot
// Operation
// - Read data changes on serial clock fall
// - Serial input sampled on serial clock rise
// - Deselected device floats its serial output
// - Deselect means standby unless storing
// - Select low activates, ready for sequence
// - Nothing before first select falling edge
// - Pause freezes sequence, resumes after release
// - Host pauses only while clock low
// - Host resumes only while clock low
// - Unused pause input held high
// - Slot pins give address low bits
// - Mismatched slot address gets no response
// - At most four devices per bus
// - Each pot: wiper plus four stored
// - Wiper selects exactly one tap
// - Reset recalls stored zero into wiper
// - First byte after select is identification
// - Type code checked before continuing
// - Host sends zeros in spare bits
// - Second byte: opcode, register, pot
`timescale 1ns/1ps
module qps_device import qps_pkg::*; #(
  parameter int NV_WRITE_CYCLES = NV_WRITE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  qps_link_if.device link,
  input wire logic [1:0] busSlotPins,
  output logic [NUM_POTS*8-1:0] wiperPos,
  output logic [NUM_POTS*TAPS-1:0] tapSel,
  output logic standby,
  output logic nvBusy
);
  localparam int BW = $clog2(NV_WRITE_CYCLES + 1);

  typedef enum {D_IDLE, D_ID, D_INSTR, D_WDATA, D_RDATA, D_DONE} qps_dev_e;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [5:0] syncQ;
  logic sSck, sSi, sCsN, sHoldN;
  logic [1:0] sSlot;

  qps_sync #(.W(6)) u_sync (
    .clk(clk),
    .reset(reset),
    .d({link.sck, link.si, link.csN, link.holdN, busSlotPins}),
    .q(syncQ)
  );
  assign {sSck, sSi, sCsN, sHoldN, sSlot} = syncQ;

  // ----------------------------------------
  // State
  // ----------------------------------------
  qps_dev_e state_reg, state_next;
  logic sckQ_reg, sckQ_next;
  logic csQ_reg, csQ_next;
  logic armed_reg, armed_next;
  logic recall_reg, recall_next;
  logic [2:0] bitCnt_reg, bitCnt_next;
  logic [7:0] shIn_reg, shIn_next;
  logic [7:0] shOut_reg, shOut_next;
  logic [3:0] op_reg, op_next;
  logic [3:0] sel_reg, sel_next;
  logic soOut_reg, soOut_next;
  logic [7:0] wiper_reg [NUM_POTS];
  logic [7:0] wiper_next [NUM_POTS];
  logic [7:0] stored_reg [NUM_POTS][NUM_STORED];
  logic [7:0] stored_next [NUM_POTS][NUM_STORED];
  logic pend_reg, pend_next;
  logic [1:0] pendPot_reg, pendPot_next;
  logic [1:0] pendIdx_reg, pendIdx_next;
  logic [7:0] pendData_reg, pendData_next;
  logic [BW-1:0] busy_reg, busy_next;
  logic sckRise, sckFall, csFall, csRise, active;
  logic [7:0] byteIn;
  logic [1:0] pot, idx;

  // Edge detection on second synchroniser stage only
  assign sckRise = sSck & ~sckQ_reg;
  assign sckFall = ~sSck & sckQ_reg;
  assign csFall = ~sCsN & csQ_reg;
  assign csRise = sCsN & ~csQ_reg;
  assign active = armed_reg & ~sCsN & sHoldN;
  assign byteIn = {shIn_reg[6:0], sSi};
  assign pot = sel_reg[POT_HI:POT_LO];
  assign idx = sel_reg[REG_HI:REG_LO];

  // ----------------------------------------
  // Sequence and register next-state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    sckQ_next = sSck;
    csQ_next = sCsN;
    armed_next = armed_reg;
    recall_next = 1'b1;
    bitCnt_next = bitCnt_reg;
    shIn_next = shIn_reg;
    shOut_next = shOut_reg;
    op_next = op_reg;
    sel_next = sel_reg;
    soOut_next = soOut_reg;
    wiper_next = wiper_reg;
    stored_next = stored_reg;
    pend_next = pend_reg;
    pendPot_next = pendPot_reg;
    pendIdx_next = pendIdx_reg;
    pendData_next = pendData_reg;
    busy_next = (busy_reg != '0) ? busy_reg - 1'b1 : busy_reg;
    // Recall runs once after reset release, from live stored values
    if (!recall_reg) begin
      for (int p = 0; p < NUM_POTS; p++) begin
        wiper_next[p] = stored_reg[p][0];
      end
    end
    if (csFall) begin
      armed_next = 1'b1;
    end
    if (sCsN) begin
      // Abort any partial sequence; commit a finished store
      state_next = D_IDLE;
      if (csRise && pend_reg) begin
        stored_next[pendPot_reg][pendIdx_reg] = pendData_reg;
        pend_next = 1'b0;
        busy_next = BW'(NV_WRITE_CYCLES - 1);
      end
    end else if (csFall) begin
      // Busy device ignores the whole new sequence
      state_next = (busy_reg == '0) ? D_ID : D_DONE;
      bitCnt_next = '0;
    end else if (active && state_reg != D_IDLE) begin
      if (sckRise && (state_reg == D_ID || state_reg == D_INSTR ||
          state_reg == D_WDATA)) begin
        shIn_next = byteIn;
        bitCnt_next = bitCnt_reg + 3'h1;
        if (bitCnt_reg == 3'h7) begin
          case (state_reg)
            D_ID: begin
              if (byteIn[ID_TYPE_HI:ID_TYPE_LO] == TYPE_CODE &&
                  byteIn[ID_SLOT_HI:ID_SLOT_LO] == sSlot) begin
                state_next = D_INSTR;
              end else begin
                state_next = D_DONE;
              end
            end
            D_INSTR: begin
              op_next = byteIn[OP_HI:OP_LO];
              sel_next = byteIn[REG_HI:POT_LO];
              state_next = D_DONE;
              case (byteIn[OP_HI:OP_LO])
                OP_RD_WIPER: begin
                  shOut_next = wiper_reg[byteIn[POT_HI:POT_LO]];
                  state_next = D_RDATA;
                end
                OP_RD_STORED: begin
                  shOut_next = stored_reg[byteIn[POT_HI:POT_LO]][byteIn[REG_HI:REG_LO]];
                  state_next = D_RDATA;
                end
                OP_WR_WIPER, OP_WR_STORED: begin
                  state_next = D_WDATA;
                end
                OP_XFR_S2W: begin
                  wiper_next[byteIn[POT_HI:POT_LO]] =
                    stored_reg[byteIn[POT_HI:POT_LO]][byteIn[REG_HI:REG_LO]];
                end
                OP_XFR_W2S: begin
                  pend_next = 1'b1;
                  pendPot_next = byteIn[POT_HI:POT_LO];
                  pendIdx_next = byteIn[REG_HI:REG_LO];
                  pendData_next = wiper_reg[byteIn[POT_HI:POT_LO]];
                end
                default: begin
                  state_next = D_DONE;
                end
              endcase
            end
            D_WDATA: begin
              state_next = D_DONE;
              if (op_reg == OP_WR_WIPER) begin
                wiper_next[pot] = byteIn;
              end else begin
                pend_next = 1'b1; // Stored only when select rises
                pendPot_next = pot;
                pendIdx_next = idx;
                pendData_next = byteIn;
              end
            end
            default: begin
              state_next = D_DONE;
            end
          endcase
        end
      end
      if (sckFall && state_reg == D_RDATA) begin
        soOut_next = shOut_reg[7];
        shOut_next = {shOut_reg[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= D_IDLE;
      sckQ_reg <= 1'b0;
      // Matches the synchroniser's reset output, so no false select edge
      csQ_reg <= 1'b0;
      armed_reg <= 1'b0;
      recall_reg <= 1'b0;
      bitCnt_reg <= '0;
      shIn_reg <= '0;
      shOut_reg <= '0;
      op_reg <= '0;
      sel_reg <= '0;
      soOut_reg <= 1'b0;
      pend_reg <= 1'b0;
      pendPot_reg <= '0;
      pendIdx_reg <= '0;
      pendData_reg <= '0;
      busy_reg <= '0;
      for (int p = 0; p < NUM_POTS; p++) begin
        wiper_reg[p] <= '0;
        for (int r = 0; r < NUM_STORED; r++) begin
          stored_reg[p][r] <= STORED_RESET;
        end
      end
    end else begin
      state_reg <= state_next;
      sckQ_reg <= sckQ_next;
      csQ_reg <= csQ_next;
      armed_reg <= armed_next;
      recall_reg <= recall_next;
      bitCnt_reg <= bitCnt_next;
      shIn_reg <= shIn_next;
      shOut_reg <= shOut_next;
      op_reg <= op_next;
      sel_reg <= sel_next;
      soOut_reg <= soOut_next;
      pend_reg <= pend_next;
      pendPot_reg <= pendPot_next;
      pendIdx_reg <= pendIdx_next;
      pendData_reg <= pendData_next;
      busy_reg <= busy_next;
      wiper_reg <= wiper_next;
      stored_reg <= stored_next;
    end
  end

  // ----------------------------------------
  // Outputs and tap decode
  // ----------------------------------------
  assign link.so = soOut_reg;
  assign link.soOe = (state_reg == D_RDATA) & ~sCsN & sHoldN;
  assign nvBusy = (busy_reg != '0);
  assign standby = sCsN & ~nvBusy & ~pend_reg;

  for (genvar p = 0; p < NUM_POTS; p++) begin : g_pot
    assign wiperPos[p*8 +: 8] = wiper_reg[p];
    for (genvar t = 0; t < TAPS; t++) begin : g_tap
      assign tapSel[p*TAPS + t] = (wiper_reg[p] == 8'(t));
    end
  end
endmodule

//--- design/qps_host.sv
// Host end: serial master that runs one command per start
`timescale 1ns/1ps
module qps_host import qps_pkg::*; #(
  parameter int HALF = SCK_HALF_CYC
) (
  input wire logic clk,
  input wire logic reset,
  qps_link_if.host link,
  input wire logic start,
  input wire logic [1:0] slot,
  input wire logic [3:0] opcode,
  input wire logic [1:0] regSel,
  input wire logic [1:0] potSel,
  input wire logic [7:0] wrData,
  input wire logic pauseReq,
  output logic busy,
  output logic done,
  output logic [7:0] rdData
);
  typedef enum {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_HOLD, H_TAIL, H_GAP} qps_host_e;

  logic soSync;
  qps_host_e st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [4:0] nBits_reg, nBits_next;
  logic [23:0] tx_reg, tx_next;
  logic [7:0] rx_reg, rx_next;
  logic csN_reg, csN_next;
  logic sck_reg, sck_next;
  logic si_reg, si_next;
  logic holdN_reg, holdN_next;
  logic done_reg, done_next;
  logic [7:0] rd_reg, rd_next;
  logic shortCmd;

  qps_sync #(.W(1)) u_sync (
    .clk(clk),
    .reset(reset),
    .d(link.soOe ? link.so : 1'b1), // Released line reads as pulled up
    .q(soSync)
  );

  // Transfer commands end after the instruction byte
  assign shortCmd = (opcode == OP_XFR_S2W) || (opcode == OP_XFR_W2S);

  // ----------------------------------------
  // Sequencer; serial clock made by dividing clk
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    cnt_next = (cnt_reg != '0) ? cnt_reg - 8'h01 : cnt_reg;
    nBits_next = nBits_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    csN_next = csN_reg;
    sck_next = sck_reg;
    si_next = si_reg;
    holdN_next = 1'b1;
    done_next = 1'b0;
    rd_next = rd_reg;
    case (st_reg)
      H_IDLE: begin
        if (start) begin
          // Spare identification bits sent as zero
          tx_next = {TYPE_CODE, 2'b00, slot, opcode, regSel, potSel, wrData};
          nBits_next = shortCmd ? 5'h10 : 5'h18;
          csN_next = 1'b0;
          cnt_next = 8'(HALF - 1);
          st_next = H_LEAD;
        end
      end
      H_LEAD: begin
        if (cnt_reg == '0) begin
          si_next = tx_reg[23];
          tx_next = {tx_reg[22:0], 1'b0};
          cnt_next = 8'(HALF - 1);
          st_next = H_LOW;
        end
      end
      H_LOW: begin
        if (pauseReq) begin
          holdN_next = 1'b0;
          st_next = H_HOLD;
        end else if (cnt_reg == '0) begin
          sck_next = 1'b1;
          cnt_next = 8'(HALF - 1);
          st_next = H_HIGH;
        end
      end
      H_HOLD: begin
        holdN_next = 1'b0;
        if (!pauseReq) begin
          holdN_next = 1'b1;
          cnt_next = 8'(HALF - 1);
          st_next = H_LOW;
        end
      end
      H_HIGH: begin
        if (cnt_reg == '0) begin
          rx_next = {rx_reg[6:0], soSync};
          sck_next = 1'b0;
          nBits_next = nBits_reg - 5'h01;
          cnt_next = 8'(HALF - 1);
          if (nBits_reg == 5'h01) begin
            st_next = H_TAIL;
          end else begin
            si_next = tx_reg[23];
            tx_next = {tx_reg[22:0], 1'b0};
            st_next = H_LOW;
          end
        end
      end
      H_TAIL: begin
        if (cnt_reg == '0) begin
          csN_next = 1'b1;
          cnt_next = 8'(HALF - 1);
          st_next = H_GAP;
        end
      end
      H_GAP: begin
        if (cnt_reg == '0) begin
          done_next = 1'b1;
          rd_next = rx_reg;
          st_next = H_IDLE;
        end
      end
      default: begin
        st_next = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= H_IDLE;
      cnt_reg <= '0;
      nBits_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
      csN_reg <= 1'b1;
      sck_reg <= 1'b0;
      si_reg <= 1'b0;
      holdN_reg <= 1'b1;
      done_reg <= 1'b0;
      rd_reg <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      nBits_reg <= nBits_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      csN_reg <= csN_next;
      sck_reg <= sck_next;
      si_reg <= si_next;
      holdN_reg <= holdN_next;
      done_reg <= done_next;
      rd_reg <= rd_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.csN = csN_reg;
  assign link.sck = sck_reg;
  assign link.si = si_reg;
  assign link.holdN = holdN_reg;
  assign busy = (st_reg != H_IDLE);
  assign done = done_reg;
  assign rdData = rd_reg;
endmodule

//--- design/qps_link_if.sv
// Serial link between host and pot device
`timescale 1ns/1ps
interface qps_link_if;
  logic sck;
  logic csN;
  logic holdN;
  logic si;
  logic so;
  logic soOe;

  // Device drives only the serial output and its enable
  modport device (
    input sck,
    input csN,
    input holdN,
    input si,
    output so,
    output soOe
  );
  modport host (
    output sck,
    output csN,
    output holdN,
    output si,
    input so,
    input soOe
  );
endinterface

//--- design/qps_pkg.sv
// Shared constants for the quad pot serial front end
package qps_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int NUM_POTS = 4;
  localparam int NUM_STORED = 4;
  localparam int TAPS = 256;
  // ----------------------------------------
  // Identification byte fields
  // ----------------------------------------
  localparam logic [3:0] TYPE_CODE = 4'hA; // Arbitrary value, not a real part code
  localparam int ID_TYPE_HI = 7;
  localparam int ID_TYPE_LO = 4;
  localparam int ID_SLOT_HI = 1;
  localparam int ID_SLOT_LO = 0;
  // ----------------------------------------
  // Instruction byte fields and operation codes
  // ----------------------------------------
  localparam int OP_HI = 7;
  localparam int OP_LO = 4;
  localparam int REG_HI = 3;
  localparam int REG_LO = 2;
  localparam int POT_HI = 1;
  localparam int POT_LO = 0;
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_STORED = 4'hB;
  localparam logic [3:0] OP_WR_STORED = 4'hC;
  localparam logic [3:0] OP_XFR_S2W = 4'hD;
  localparam logic [3:0] OP_XFR_W2S = 4'hE;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:0] STORED_RESET = 8'h80;
  localparam int CLK_MHZ = 125;
  localparam int NV_WRITE_MS = 10;
  localparam int NV_WRITE_CYC = NV_WRITE_MS * 1000 * CLK_MHZ;
  localparam int SCK_HALF_CYC = 8;
endpackage

//--- design/qps_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module qps_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // ----------------------------------------
  // Stages; first stage feeds only the second
  // ----------------------------------------
  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= meta_next;
      q <= q_next;
    end
  end
endmodule

//--- sim/qps_link_monitor.sv
// Concurrent checks on the host-to-device serial link
`timescale 1ns/1ps
module qps_link_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic sck,
  input wire logic csN,
  input wire logic holdN,
  input wire logic si,
  input wire logic so,
  input wire logic soOe
);
  // ----------------------------------------
  // Link checks
  // ----------------------------------------
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Pin inputs pass a 2-flop sync, hence the few cycles of slack
  a_float_deselected: assert property (csN [*5] |-> !soOe)
    else $error("so driven while deselected");
  a_abort_floats: assert property ($rose(csN) |-> ##[0:4] !soOe)
    else $error("so still driven after deselect");
  a_quiet_after_select: assert property ($fell(csN) |-> !soOe [*8])
    else $error("so driven during first byte");
  a_so_moves_low: assert property (soOe && $past(soOe) && $changed(so) |-> !sck)
    else $error("so changed with clock high");
  a_si_held_rise: assert property ($rose(sck) |-> $stable(si))
    else $error("si moved on sampling edge");
  a_pause_floats: assert property (!holdN [*5] |-> !soOe)
    else $error("so driven while paused");
  a_pause_clock_low: assert property ($fell(holdN) |-> !sck)
    else $error("pause with clock high");
  a_resume_clock_low: assert property ($rose(holdN) |-> !sck)
    else $error("resume with clock high");
  a_clock_frozen: assert property (!holdN |-> !sck)
    else $error("clock ran while paused");
  a_frame_only_clock: assert property (csN |-> !sck)
    else $error("clock high outside frame");
  // Main traffic kinds
  c_read_drive: cover property ($rose(soOe));
  c_pause: cover property ($fell(holdN));
  c_select: cover property ($fell(csN));
endmodule

//--- sim/tb_quad_pot_serial_slave_front_end.sv
// Bench: host end drives device end over the shared serial link
`timescale 1ns/1ps
module tb_quad_pot_serial_slave_front_end;
  import qps_pkg::*;
  // Short store time keeps the run brief
  localparam int NV_CYC = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0, pauseReq = 1'b0;
  logic [1:0] slot = 2'h0, regSel = 2'h0, potSel = 2'h0, busSlotPins = 2'h0;
  logic [3:0] opcode = 4'h0;
  logic [7:0] wrData = 8'h00;
  logic busy, done, standby, nvBusy, nvSeen, stbyBad, actSeen;
  logic [7:0] rdData;
  logic [NUM_POTS*8-1:0] wiperPos;
  logic [NUM_POTS*TAPS-1:0] tapSel;
  int badCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  // ----------------------------------------
  // Ends, link and checker
  // ----------------------------------------
  qps_link_if link ();
  qps_device #(.NV_WRITE_CYCLES(NV_CYC)) u_qps_device (
    .clk(clk), .reset(reset), .link(link.device), .busSlotPins(busSlotPins),
    .wiperPos(wiperPos), .tapSel(tapSel), .standby(standby), .nvBusy(nvBusy)
  );
  qps_host u_qps_host (
    .clk(clk), .reset(reset), .link(link.host), .start(start), .slot(slot),
    .opcode(opcode), .regSel(regSel), .potSel(potSel), .wrData(wrData),
    .pauseReq(pauseReq), .busy(busy), .done(done), .rdData(rdData)
  );
  qps_link_monitor u_qps_link_monitor (
    .clk(clk), .reset(reset), .sck(link.sck), .csN(link.csN), .holdN(link.holdN),
    .si(link.si), .so(link.so), .soOe(link.soOe)
  );
  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end
  // Hang guard: the scenarios need under 20000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      badCount++;
      wrapUp();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wrapUp();
    if (badCount == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Wiper value plus its one-hot tap decode
  task automatic chkPot(input int p, input logic [7:0] v);
    chk("wiper", v, wiperPos[p*8 +: 8]);
    chk("taps on", 8'h01, 8'($countones(tapSel[p*TAPS +: TAPS])));
    chk("tap bit", 8'h01, {7'h00, tapSel[p*TAPS + int'(v)]});
  endtask
  // Start is only offered in idle, one pulse long
  task automatic issue(input logic [1:0] s, input logic [3:0] op, input logic [1:0] r,
                       input logic [1:0] p, input logic [7:0] d);
    @(posedge clk);
    slot <= s;
    opcode <= op;
    regSel <= r;
    potSel <= p;
    wrData <= d;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  // Waits for done, then lets any store run out before the next select
  task automatic finish();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (link.csN === 1'b0 && link.sck === 1'b1 && standby === 1'b0) actSeen = 1'b1;
    end while (done !== 1'b1 && n < 3000);
    chk("done", 8'h01, {7'h00, done});
    chk("host idle", 8'h00, {7'h00, busy});
    n = 0;
    while (nvBusy !== 1'b0 && n < 200) begin
      nvSeen = 1'b1;
      if (standby !== 1'b0) stbyBad = 1'b1;
      @(posedge clk);
      #1;
      n++;
    end
    repeat (4) @(posedge clk);
    #1;
    chk("standby", 8'h01, {7'h00, standby});
  endtask
  task automatic go(input logic [1:0] s, input logic [3:0] op, input logic [1:0] r,
                    input logic [1:0] p, input logic [7:0] d);
    issue(s, op, r, p, d);
    finish();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tPowerUp();
    for (int p = 0; p < NUM_POTS; p++) begin
      chkPot(p, STORED_RESET);
      go(2'h0, OP_RD_STORED, 2'h0, 2'(p), 8'h00);
      chk("stored zero", STORED_RESET, rdData);
    end
  endtask
  // Boundary and mid-range wiper values written and read back
  task automatic tWiper();
    logic [7:0] v;
    for (int p = 0; p < NUM_POTS; p++) begin
      v = (p == 0) ? 8'h00 : (p == 1) ? 8'hFF : 8'h5A ^ 8'(p);
      actSeen = 1'b0;
      go(2'h0, OP_WR_WIPER, 2'h0, 2'(p), v);
      chkPot(p, v);
      chk("active", 8'h01, {7'h00, actSeen});
      go(2'h0, OP_RD_WIPER, 2'h0, 2'(p), 8'h00);
      chk("read wiper", v, rdData);
    end
  endtask
  // Each stored index written, timed, read and recalled, on one pot per index
  task automatic tStored();
    logic [7:0] v;
    for (int r = 0; r < NUM_STORED; r++) begin
      v = 8'hC3 ^ 8'(r * 17);
      nvSeen = 1'b0;
      stbyBad = 1'b0;
      go(2'h0, OP_WR_STORED, 2'(r), 2'(3 - r), v);
      chk("store busy", 8'h01, {7'h00, nvSeen});
      chk("standby in store", 8'h00, {7'h00, stbyBad});
      go(2'h0, OP_RD_STORED, 2'(r), 2'(3 - r), 8'h00);
      chk("read stored", v, rdData);
      go(2'h0, OP_XFR_S2W, 2'(r), 2'(3 - r), 8'h00);
      chkPot(3 - r, v);
    end
    go(2'h0, OP_WR_WIPER, 2'h0, 2'h0, 8'h69);
    go(2'h0, OP_XFR_W2S, 2'h2, 2'h0, 8'h00);
    go(2'h0, OP_RD_STORED, 2'h2, 2'h0, 8'h00);
    chk("wiper to stored", 8'h69, rdData);
  endtask
  // Pause lands in the read data phase, so the output must float
  task automatic tPause();
    go(2'h0, OP_WR_WIPER, 2'h0, 2'h1, 8'hC6);
    issue(2'h0, OP_RD_WIPER, 2'h0, 2'h1, 8'h00);
    repeat (320) @(posedge clk);
    pauseReq <= 1'b1;
    repeat (60) @(posedge clk);
    #1;
    chk("pause pin", 8'h00, {7'h00, link.holdN});
    chk("paused drive", 8'h00, {7'h00, link.soOe});
    chk("paused done", 8'h00, {7'h00, done});
    @(posedge clk);
    pauseReq <= 1'b0;
    finish();
    chk("resumed read", 8'hC6, rdData);
  endtask
  // Each strap answers its own address and ignores the address with bit 0 flipped
  task automatic tSlots();
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      busSlotPins <= 2'(s);
      repeat (4) @(posedge clk);
      go(2'(s), OP_WR_WIPER, 2'h0, 2'h3, 8'(16 * s + 7));
      chkPot(3, 8'(16 * s + 7));
      go(2'(s) ^ 2'h1, OP_WR_WIPER, 2'h0, 2'h3, 8'hEE);
      chkPot(3, 8'(16 * s + 7));
    end
    // Unknown operation leaves the wiper alone
    go(2'h3, 4'h3, 2'h0, 2'h3, 8'h11);
    chkPot(3, 8'h37);
  endtask
  // Reset, then scenarios in turn
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    tPowerUp();
    tWiper();
    tStored();
    tPause();
    tSlots();
    wrapUp();
  end
endmodule
